// [design/arinc_rx_pkg.sv]
`default_nettype none
package arinc_rx_pkg;
    localparam int WORD_BITS = 32;
    localparam int FIFO_DEPTH = 32;
    localparam logic [5:0] FIFO_HALF_LEVEL = 6'h10;
    localparam logic [7:0] OP_MASTER_RESET = 8'h01;
    localparam logic [7:0] OP_LUT_CLEAR = 8'h02;
    localparam logic [7:0] OP_LUT_FILL = 8'h03;
    localparam logic [7:0] OP_LUT_RESET_ONE = 8'h04;
    localparam logic [7:0] OP_LUT_SET_ONE = 8'h05;
    localparam logic [7:0] OP_LUT_WRITE = 8'h06;
    localparam logic [7:0] OP_DIV_WRITE = 8'h07;
    localparam logic [7:0] OP_FIFO_READ = 8'h08;
    localparam logic [7:0] OP_FIFO_DUMP = 8'h09;
    localparam logic [7:0] OP_STATUS_READ = 8'h0a;
    localparam logic [7:0] OP_CTRL_READ = 8'h0b;
    localparam logic [7:0] OP_DIV_READ = 8'h0c;
    localparam logic [7:0] OP_LUT_READ = 8'h0d;
    localparam logic [7:0] OP_CTRL_WRITE = 8'h10;
    localparam logic [8:0] OP_LAST_BIT = 9'h007;
    localparam logic [8:0] LEN_BYTE = 9'h008;
    localparam logic [8:0] LEN_CTRL = 9'h010;
    localparam logic [8:0] LEN_LUT = 9'h100;
    localparam logic [5:0] OUT_WORD_BITS = 6'h20;
    localparam logic [2:0] LUT_LAST_CHUNK = 3'h7;
    localparam logic [6:0] RATE_DIV_HIGH = 7'h0a;
    localparam logic [6:0] RATE_DIV_LOW = 7'h50;
    localparam logic [7:0] DIV_X1 = 8'h01;
    localparam logic [7:0] DIV_X2 = 8'h02;
    localparam logic [7:0] DIV_X4 = 8'h04;
    localparam logic [7:0] DIV_X8 = 8'h08;
    localparam logic [7:0] DIV_XA = 8'h0a;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [255:0] LUT_RESET = 256'h0;
    localparam logic FLAG_RESET = 1'b1;
    localparam int PIN_DIN = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_MCLR = 3;
    localparam int PIN_ACLK = 4;
    localparam logic [4:0] SYNC_RESET = 5'h04;

    typedef struct packed {
        logic flagMeaningBit;
        logic [2:0] unusedHigh;
        logic labelOrderBit;
        logic [1:0] unusedMid;
        logic bitNineMatchSetting;
        logic bitTenMatchSetting;
        logic decoderEnableBit;
        logic receiverOnBit;
        logic parityCheckBit;
        logic unusedLow;
        logic labelFilterEnableBit;
        logic clockSourceBit;
        logic rateSelectBit;
    } ctrl_t;

    typedef struct packed {
        logic [1:0] alwaysZero;
        logic [2:0] undefinedBits;
        logic fifoFullBit;
        logic fifoHalfBit;
        logic fifoEmptyBit;
    } status_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } rx_word_t;

    typedef enum logic [1:0] {SPI_OPCODE, SPI_WRITE, SPI_READ, SPI_IGNORE} spi_state_t;
endpackage
`default_nettype wire

// [design/rx_word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic outValid_reg;
    logic [WIDTH-1:0] outData_reg;
    logic pop;
    logic push;
    logic overwrite;
    logic [AW-1:0] wrIndex;

    // A word arriving while full replaces the newest one instead of being lost silently
    assign inReady = (count_reg != FULL_COUNT);
    assign pop = outReady && outValid_reg;
    assign push = inValid && (inReady || pop);
    assign overwrite = inValid && !inReady && !pop;
    assign wrIndex = overwrite ? wrPtr_reg - AW'(1) : wrPtr_reg;
    assign outValid = outValid_reg;
    assign outData = outData_reg;
    assign level = count_reg;

    always_ff @(posedge clk) begin
        if (push || overwrite) begin
            mem[wrIndex] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_reg + AW'(push);
            rdPtr_reg <= rdPtr_reg + AW'(pop);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Head data and its valid both lag the pointer by one cycle so they stay paired
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outValid_reg <= 1'b0;
            outData_reg <= '0;
        end else begin
            outValid_reg <= (count_reg != '0) && !pop && !flush;
            outData_reg <= mem[rdPtr_reg];
        end
    end

    fullHolds_a: assert property (@(posedge clk) disable iff (rst)
        overwrite && !flush |=> count_reg == FULL_COUNT)
        else $error("overwrite changed the fill level");
endmodule // rx_word_fifo
`default_nettype wire

// [design/arinc_rx_spi_command_and_config.sv]
`timescale 1ns/1ps
`default_nettype none
module arinc_rx_spi_command_and_config
    import arinc_rx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic spiClk,
    input wire logic spiSelN,
    input wire logic spiDataIn,
    output logic spiDataOut,
    input wire logic timingClk,
    input wire logic masterClear,
    input wire rx_word_t rxWord,
    output logic arincClkTick,
    output logic bitRateTick,
    output logic fifoFlagPin
);
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7-i];
        end
    endfunction

    // ARINC bit n sits at w[n-1]; the label field goes out last
    function automatic logic [31:0] mapWord(input logic [31:0] w, input logic keepOrder);
        mapWord = {w[31:8], keepOrder ? w[7:0] : rev8(w[7:0])};
    endfunction

    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] prev_reg;
    ctrl_t ctrl_reg;
    logic [7:0] div_reg;
    logic [255:0] lut_reg;
    spi_state_t state_reg;
    logic [8:0] bitCnt_reg;
    logic [7:0] opcode_reg;
    logic [15:0] inShift_reg;
    logic [31:0] outShift_reg;
    logic [5:0] outLeft_reg;
    logic [2:0] chunk_reg;
    logic dout_reg;
    logic flag_reg;
    logic [7:0] divCnt_reg;
    logic [6:0] rateCnt_reg;
    logic arincTick_reg;
    logic bitTick_reg;

    // Pins come from other clocks; levels are taken from the second stage, edges from the second and third
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
            prev_reg <= SYNC_RESET;
        end else begin
            sync1_reg <= {timingClk, masterClear, spiSelN, spiClk, spiDataIn};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    logic selActive;
    logic sckRise;
    logic sckFall;
    logic aclkRise;
    logic din;
    logic mclrLevel;
    assign selActive = !sync2_reg[PIN_SEL];
    assign sckRise = sync2_reg[PIN_SCK] && !prev_reg[PIN_SCK];
    assign sckFall = !sync2_reg[PIN_SCK] && prev_reg[PIN_SCK];
    assign aclkRise = sync2_reg[PIN_ACLK] && !prev_reg[PIN_ACLK];
    assign din = sync2_reg[PIN_DIN];
    assign mclrLevel = sync2_reg[PIN_MCLR];

    // Command decode
    logic [7:0] opNow;
    logic opDone;
    logic opIsWrite;
    logic opIsRead;
    spi_state_t opState;
    logic [8:0] wrLen;
    logic wrBit;
    logic wrLast;
    logic [15:0] wrWord;
    assign opNow = {inShift_reg[6:0], din};
    assign opDone = selActive && sckRise && state_reg == SPI_OPCODE && bitCnt_reg == OP_LAST_BIT;
    assign opIsWrite = opNow == OP_LUT_RESET_ONE || opNow == OP_LUT_SET_ONE || opNow == OP_LUT_WRITE
        || opNow == OP_DIV_WRITE || opNow == OP_CTRL_WRITE;
    assign opIsRead = opNow >= OP_FIFO_READ && opNow <= OP_LUT_READ;
    // Unlisted codes, 0Eh and 0Fh included, fall to the ignore state
    assign opState = opIsWrite ? SPI_WRITE : opIsRead ? SPI_READ : SPI_IGNORE;
    assign wrLen = opcode_reg == OP_CTRL_WRITE ? LEN_CTRL : opcode_reg == OP_LUT_WRITE ? LEN_LUT : LEN_BYTE;
    assign wrBit = selActive && sckRise && state_reg == SPI_WRITE;
    assign wrLast = wrBit && bitCnt_reg == wrLen - 9'h001;
    assign wrWord = {inShift_reg[14:0], din};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SPI_OPCODE;
            bitCnt_reg <= '0;
            opcode_reg <= '0;
            inShift_reg <= '0;
        end else if (!selActive) begin
            state_reg <= SPI_OPCODE;
            bitCnt_reg <= '0;
        end else if (sckRise) begin
            inShift_reg <= wrWord;
            bitCnt_reg <= bitCnt_reg + 9'h001;
            case (state_reg)
                SPI_OPCODE: begin
                    if (opDone) begin
                        state_reg <= opState;
                        opcode_reg <= opNow;
                        bitCnt_reg <= '0;
                    end
                end
                SPI_WRITE: begin
                    if (wrLast) begin
                        state_reg <= SPI_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Configuration writes; every control bit is kept, used or not
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            div_reg <= DIV_RESET;
        end else if (wrLast) begin
            if (opcode_reg == OP_CTRL_WRITE) begin
                ctrl_reg <= wrWord;
            end
            if (opcode_reg == OP_DIV_WRITE) begin
                div_reg <= wrWord[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lut_reg <= LUT_RESET;
        end else if (opDone && opNow == OP_LUT_CLEAR) begin
            lut_reg <= '0;
        end else if (opDone && opNow == OP_LUT_FILL) begin
            lut_reg <= '1;
        end else if (wrBit && opcode_reg == OP_LUT_WRITE) begin
            lut_reg[~bitCnt_reg[7:0]] <= din;
        end else if (wrLast && opcode_reg == OP_LUT_SET_ONE) begin
            lut_reg[wrWord[7:0]] <= 1'b1;
        end else if (wrLast && opcode_reg == OP_LUT_RESET_ONE) begin
            lut_reg[wrWord[7:0]] <= 1'b0;
        end
    end

    // Receive path: filtering in front of the FIFO
    logic [7:0] labelIndex;
    logic labelOk;
    logic decodeOk;
    logic parityOk;
    logic fifoPush;
    logic fifoFlush;
    logic fifoPop;
    logic fifoInReady;
    logic fifoOutValid;
    logic [31:0] fifoOutData;
    logic [5:0] fifoLevel;
    assign labelIndex = rev8(rxWord.data[7:0]);
    assign labelOk = !ctrl_reg.labelFilterEnableBit || lut_reg[labelIndex];
    assign decodeOk = !ctrl_reg.decoderEnableBit
        || (rxWord.data[9] == ctrl_reg.bitTenMatchSetting && rxWord.data[8] == ctrl_reg.bitNineMatchSetting);
    assign parityOk = !ctrl_reg.parityCheckBit || ^rxWord.data;
    assign fifoPush = rxWord.valid && ctrl_reg.receiverOnBit && labelOk && decodeOk && parityOk;
    assign fifoFlush = mclrLevel || (opDone && opNow == OP_MASTER_RESET);

    rx_word_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) receiveFifo (
        .clk(clk),
        .rst(rst),
        .flush(fifoFlush),
        .inValid(fifoPush),
        .inData(rxWord.data),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoPop),
        .level(fifoLevel)
    );

    status_t status;
    assign status.alwaysZero = 2'b00;
    assign status.undefinedBits = 3'b000;
    assign status.fifoFullBit = !fifoInReady;
    assign status.fifoHalfBit = fifoLevel >= FIFO_HALF_LEVEL;
    assign status.fifoEmptyBit = fifoLevel == '0;

    // Read data path
    logic [31:0] fifoSpiWord;
    logic [31:0] firstWord;
    logic [2:0] chunkNext;
    logic [31:0] reloadWord;
    logic outBit;
    logic reload;
    assign fifoSpiWord = fifoOutValid ? mapWord(fifoOutData, ctrl_reg.labelOrderBit) : 32'h00000000;
    assign firstWord = opNow == OP_STATUS_READ ? {status, 24'h000000}
        : opNow == OP_CTRL_READ ? {ctrl_reg, 16'h0000}
        : opNow == OP_DIV_READ ? {div_reg, 24'h000000}
        : opNow == OP_LUT_READ ? lut_reg[255 -: 32]
        : fifoSpiWord;
    assign chunkNext = chunk_reg + 3'h1;
    assign reloadWord = opcode_reg == OP_FIFO_DUMP ? fifoSpiWord
        : (opcode_reg == OP_LUT_READ && chunk_reg != LUT_LAST_CHUNK) ? lut_reg[{~chunkNext, 5'h1f} -: 32]
        : 32'h00000000;
    assign outBit = selActive && sckFall && state_reg == SPI_READ;
    assign reload = outBit && outLeft_reg == 6'h01;
    // A pop with nothing stored is dropped by the FIFO itself
    assign fifoPop = (opDone && (opNow == OP_FIFO_READ || opNow == OP_FIFO_DUMP))
        || (reload && opcode_reg == OP_FIFO_DUMP);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outShift_reg <= '0;
            outLeft_reg <= '0;
            chunk_reg <= '0;
            dout_reg <= 1'b0;
        end else if (!selActive) begin
            dout_reg <= 1'b0;
        end else if (opDone) begin
            outShift_reg <= firstWord;
            outLeft_reg <= OUT_WORD_BITS;
            chunk_reg <= '0;
        end else if (outBit) begin
            dout_reg <= outShift_reg[31];
            outShift_reg <= reload ? reloadWord : {outShift_reg[30:0], 1'b0};
            outLeft_reg <= reload ? OUT_WORD_BITS : outLeft_reg - 6'h01;
            chunk_reg <= reload ? chunkNext : chunk_reg;
        end
    end
    assign spiDataOut = dout_reg;

    // Flag pin meaning follows the control word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_reg <= FLAG_RESET;
        end else begin
            flag_reg <= ctrl_reg.flagMeaningBit ? status.fifoFullBit : status.fifoEmptyBit;
        end
    end
    assign fifoFlagPin = flag_reg;

    // Timing clock chain; an unsupported divide value stops the clock when the divider is the selected clock source
    logic divAllowed;
    logic divTick;
    logic arincTick_next;
    logic [6:0] rateLen;
    logic bitTick_next;
    assign divAllowed = div_reg == DIV_X1 || div_reg == DIV_X2 || div_reg == DIV_X4
        || div_reg == DIV_X8 || div_reg == DIV_XA;
    assign divTick = aclkRise && divAllowed && divCnt_reg == div_reg - 8'h01;
    assign arincTick_next = ctrl_reg.clockSourceBit ? divTick : aclkRise;
    assign rateLen = ctrl_reg.rateSelectBit ? RATE_DIV_LOW : RATE_DIV_HIGH;
    assign bitTick_next = arincTick_next && rateCnt_reg >= rateLen - 7'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_reg <= '0;
        end else if (aclkRise) begin
            divCnt_reg <= (divTick || !divAllowed || divCnt_reg >= div_reg) ? 8'h00 : divCnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rateCnt_reg <= '0;
            arincTick_reg <= 1'b0;
            bitTick_reg <= 1'b0;
        end else begin
            if (arincTick_next) begin
                rateCnt_reg <= bitTick_next ? 7'h00 : rateCnt_reg + 7'h01;
            end
            arincTick_reg <= arincTick_next;
            bitTick_reg <= bitTick_next;
        end
    end
    assign arincClkTick = arincTick_reg;
    assign bitRateTick = bitTick_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    emptyRead_a: assert property (opDone && opNow == OP_FIFO_READ && !fifoOutValid
        |=> outShift_reg == 32'h00000000)
        else $error("empty FIFO read did not load zeros");
    statusRead_a: assert property (opDone && opNow == OP_STATUS_READ
        |=> outShift_reg[31:24] == $past(status))
        else $error("status read loaded wrong byte");
    ctrlLoad_a: assert property (wrLast && opcode_reg == OP_CTRL_WRITE
        |=> ctrl_reg == $past(wrWord) ##1 $stable(ctrl_reg))
        else $error("control word not loaded");
    divLoad_a: assert property (wrLast && opcode_reg == OP_DIV_WRITE
        |=> div_reg == $past(wrWord[7:0]))
        else $error("divide value not loaded");
    noOp_a: assert property (opDone && (opNow == 8'h0e || opNow == 8'h0f)
        |=> state_reg == SPI_IGNORE && $stable(ctrl_reg) && $stable(lut_reg))
        else $error("reserved op code changed state");
    rxOff_a: assert property (!ctrl_reg.receiverOnBit |-> !fifoPush)
        else $error("word taken while receiver off");
    halfLevel_a: assert property ($rose(status.fifoHalfBit) |-> fifoLevel == FIFO_HALF_LEVEL)
        else $error("half flag rose away from 16 words");
    topZero_a: assert property (status[7:6] == 2'b00)
        else $error("status top bits not zero");
    flagPin_a: assert property (ctrl_reg.flagMeaningBit && status.fifoFullBit
        ##1 ctrl_reg.flagMeaningBit |-> fifoFlagPin)
        else $error("flag pin missed full");
    labelKeep_a: assert property (ctrl_reg.labelOrderBit && fifoOutValid
        |-> fifoSpiWord[7:0] == fifoOutData[7:0])
        else $error("label order not kept");
endmodule // arinc_rx_spi_command_and_config
`default_nettype wire

// [tb/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic clk,
    output logic spiClk,
    output logic spiSelN,
    output logic spiDataIn,
    input wire logic spiDataOut
);
    logic [263:0] rxBits;
    initial begin
        spiClk = 1'b0;
        spiSelN = 1'b1;
        spiDataIn = 1'b0;
        rxBits = '0;
    end
    // First bit at the top of tx; half period of 6 clk stays clear of the sync delay
    task automatic xfer(input logic [263:0] tx, input int n);
        @(negedge clk);
        spiSelN = 1'b0;
        for (int i = 0; i < n; i++) begin
            spiDataIn = tx[263 - i];
            repeat (6) @(negedge clk);
            spiClk = 1'b1;
            rxBits = {rxBits[262:0], spiDataOut};
            repeat (6) @(negedge clk);
            spiClk = 1'b0;
        end
        repeat (6) @(negedge clk);
        spiSelN = 1'b1;
        // Pull-down on the data pin once released
        spiDataIn = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule // spi_host_model
`default_nettype wire

// [tb/arinc_rx_spi_command_and_config_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module arinc_rx_spi_command_and_config_bench;
    import arinc_rx_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic timingClk = 1'b0;
    logic masterClear = 1'b0;
    rx_word_t rxWord = '0;
    logic spiClk, spiSelN, spiDataIn, spiDataOut, arincTick, rateTick, fifoFlagPin;
    int err_total = 0;
    int check_count = 0;
    int tickRun = 0;
    int tickGap = 0;
    int clkRun = 0;
    int arincGap = 0;
    logic [15:0] tCtrl [0:8] = '{16'h0000, 16'h0020, 16'h00e0, 16'h00e0, 16'h0030, 16'h0030,
        16'h0024, 16'h0024, 16'h0820};
    logic [31:0] tWord [0:8] = '{32'h80000201, 32'h80000301, 32'h80000201, 32'h80000101,
        32'h80000201, 32'h80000301, 32'h000002a0, 32'h80000201, 32'h80000201};
    logic [8:0] tAcc = 9'b011010011;

    always #2 clk = ~clk;
    initial begin
        #3;
        forever #20 timingClk = ~timingClk;
    end

    arinc_rx_spi_command_and_config DUT (.clk(clk), .rst(rst), .spiClk(spiClk), .spiSelN(spiSelN),
        .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .timingClk(timingClk), .masterClear(masterClear),
        .rxWord(rxWord), .arincClkTick(arincTick), .bitRateTick(rateTick), .fifoFlagPin(fifoFlagPin));
    spi_host_model host (.clk(clk), .spiClk(spiClk), .spiSelN(spiSelN), .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut));

    // Clock cycles from one ARINC tick to the next
    always @(posedge clk) begin
        if (arincTick === 1'b1) begin
            arincGap <= clkRun + 1;
            clkRun <= 0;
        end else begin
            clkRun <= clkRun + 1;
        end
    end

    // Window closes at each rate tick, so the phase of the divider does not matter
    always @(posedge clk) begin
        if (rateTick === 1'b1) begin
            tickGap <= tickRun + ((arincTick === 1'b1) ? 1 : 0);
            tickRun <= 0;
        end else if (arincTick === 1'b1) begin
            tickRun <= tickRun + 1;
        end
    end

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic op(input logic [7:0] c, input logic [31:0] d, input int n);
        host.xfer({c, d, 224'h0}, 8 + n);
    endtask

    // Bits 3 to 5 are masked: their value is free
    task automatic stat(input logic [7:0] e);
        op(OP_STATUS_READ, 32'h0, 8);
        chk(host.rxBits[7:0] & 8'hc7, e);
    endtask

    task automatic feed(input logic [31:0] w);
        @(negedge clk);
        rxWord = '{valid: 1'b1, data: w};
        @(negedge clk);
        rxWord.valid = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    function automatic logic [31:0] spiWord(input logic [31:0] d, input logic ord);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = d[7 - i];
        spiWord = {d[31:8], ord ? d[7:0] : r};
    endfunction

    initial begin
        #300000;
        err_total++;
        conclude();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        stat(8'h01);
        chk(fifoFlagPin, 1'b1);
        op(OP_CTRL_WRITE, 32'h72280000, 16);
        op(OP_CTRL_READ, 32'h0, 16);
        chk(host.rxBits[15:0], 16'h7228);
        op(8'h0e, 32'hffffffff, 16);
        op(8'h0f, 32'hffffffff, 16);
        op(OP_CTRL_READ, 32'h0, 16);
        chk(host.rxBits[15:0], 16'h7228);
        op(OP_DIV_WRITE, 32'h04000000, 8);
        op(OP_DIV_READ, 32'h0, 8);
        chk(host.rxBits[7:0], 8'h04);
        op(OP_LUT_FILL, 32'h0, 0);
        op(OP_LUT_RESET_ONE, 32'h05000000, 8);
        op(OP_LUT_READ, 32'h0, 256);
        chk(host.rxBits[255:0], ~(256'h1 << 5));
        for (int i = 0; i < 9; i++) begin
            op(OP_CTRL_WRITE, {tCtrl[i], 16'h0}, 16);
            feed(tWord[i]);
            stat(tAcc[8 - i] ? 8'h00 : 8'h01);
            if (tAcc[8 - i]) begin
                op(OP_FIFO_READ, 32'h0, 32);
                chk(host.rxBits[31:0], spiWord(tWord[i], tCtrl[i][11]));
            end
        end
        op(OP_LUT_CLEAR, 32'h0, 0);
        op(OP_LUT_SET_ONE, 32'h05000000, 8);
        op(OP_LUT_READ, 32'h0, 256);
        chk(host.rxBits[255:0], 256'h1 << 5);
        op(OP_LUT_WRITE, 32'hb0000000, 256);
        op(OP_LUT_READ, 32'h0, 256);
        chk(host.rxBits[255:0], {32'hb0000000, 224'h0});
        op(OP_CTRL_WRITE, 32'h00200000, 16);
        feed(32'h12345678);
        feed(32'h87654321);
        op(OP_FIFO_DUMP, 32'h0, 96);
        chk(host.rxBits[95:0], {spiWord(32'h12345678, 1'b0), spiWord(32'h87654321, 1'b0), 32'h0});
        repeat (350) @(negedge clk);
        chk(tickGap, 10);
        chk(arincGap, 10);
        op(OP_CTRL_WRITE, 32'h00210000, 16);
        repeat (2500) @(negedge clk);
        chk(tickGap, 80);
        op(OP_CTRL_WRITE, 32'h00220000, 16);
        repeat (200) @(negedge clk);
        chk(arincGap, 40);
        op(OP_CTRL_WRITE, 32'h80200000, 16);
        for (int i = 1; i <= 32; i++) begin
            feed(i);
            if (i == 15) stat(8'h00);
            if (i == 16) stat(8'h02);
        end
        stat(8'h06);
        chk(fifoFlagPin, 1'b1);
        feed(32'hdeadbeef);
        for (int i = 1; i <= 32; i++) begin
            op(OP_FIFO_READ, 32'h0, 32);
            chk(host.rxBits[31:0], spiWord((i == 32) ? 32'hdeadbeef : i, 1'b0));
        end
        stat(8'h01);
        chk(fifoFlagPin, 1'b0);
        op(OP_FIFO_READ, 32'h0, 32);
        chk(host.rxBits[31:0], 32'h0);
        feed(32'h00000002);
        stat(8'h00);
        op(OP_MASTER_RESET, 32'h0, 0);
        stat(8'h01);
        feed(32'h00000001);
        masterClear = 1'b1;
        repeat (6) @(negedge clk);
        masterClear = 1'b0;
        repeat (6) @(negedge clk);
        stat(8'h01);
        conclude();
    end
endmodule // arinc_rx_spi_command_and_config_bench
`default_nettype wire
